/* File: core/lsd_top.sv */
// top of the legacy segment decoder: apb registers, host and peer steering
// Summary of operation
// - hole bit 7 set sends host cycles at 15-16 MB to the hub
// - peer cycles inside an enabled hole are not claimed
// - dram under the hole is never relocated, just unreachable
// - low four bits of the third dimm population register hold its code
// - population extension register turns read-only once config lock is set
// - dram decode covers at most 512 MB
// - thirteen legacy segments controlled by seven attribute registers
// - attributes apply to host and peer initiators alike
// - read enable sends host reads to dram, else to the hub
// - write enable sends host writes to dram, else to the hub
// - each attribute nibble: reserved, reserved, write enable, read enable
// - both bits clear: everything to hub, no peer claims
// - read only: reads to dram, writes to hub, peer reads only
// - write only: writes to dram, reads to hub, peer writes only
// - both bits set: host and peer reads and writes to dram
// - C0000h to DFFFFh is eight 16 KB segments, nibbles ascending
// - E0000h to EFFFFh is four 16 KB segments, nibbles ascending
// - F0000h segment uses first register high nibble, off after reset
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module lsd_top (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire lsd_pkg::lsd_apb_addr_t paddr,
   input  wire lsd_pkg::lsd_word_t    pwdata,
   output wire lsd_pkg::lsd_word_t    prdata,
   output wire logic                  pready,
   output wire logic                  pslverr,
   input  wire logic                  host_req,
   input  wire logic                  host_wr,
   input  wire lsd_pkg::lsd_addr_t    host_addr,
   output wire logic                  host_done,
   output wire logic                  host_to_dram,
   output wire logic                  host_to_hub,
   input  wire logic                  peer_req,
   input  wire logic                  peer_wr,
   input  wire lsd_pkg::lsd_addr_t    peer_addr,
   output wire logic                  peer_done,
   output wire logic                  peer_claim
);
   import lsd_pkg::*;

   logic        pready_ff;
   logic        pslverr_ff;
   logic        host_done_ff;
   logic        host_dram_ff;
   logic        host_hub_ff;
   logic        peer_done_ff;
   logic        peer_claim_ff;
   logic        nxt_pslverr;
   logic        nxt_host_dram;
   logic        nxt_host_hub;
   logic        nxt_peer_claim;
   logic        setup_w;
   logic        access_w;
   logic        aligned_w;
   logic        wr_en_w;
   lsd_byte_t   idx_w;
   lsd_byte_t   cfg_rd;
   lsd_byte_t   cfg_row2;
   logic [55:0] cfg_attr;
   logic        cfg_hole_on;
   logic        cfg_frozen;
   logic        h_legacy;
   logic        h_re;
   logic        h_we;
   logic        h_hole;
   logic        h_dram_rd;
   logic        h_dram_wr;
   logic        p_legacy;
   logic        p_re;
   logic        p_we;
   logic        p_hole;
   logic        p_dram_rd;
   logic        p_dram_wr;

   function automatic logic is_mapped(input lsd_byte_t idx);
      is_mapped = (idx == IDX_ROW_FILL1) || (idx == IDX_ROW_FILL2) ||
                  (idx == IDX_HOLE) || (idx == IDX_SYSMGMT_RAM_CTL) ||
                  ((idx >= IDX_ATTR0) && (idx < IDX_ATTR0 + 8'(NUM_ATTR)));
   endfunction

   // apb decode: register index is the word address
   assign idx_w       = paddr[9:2];
   assign aligned_w   = paddr[1:0] == 2'h0;
   assign setup_w     = psel && !penable;
   assign access_w    = psel && penable && pready_ff;
   assign nxt_pslverr = setup_w && !(aligned_w && is_mapped(idx_w));
   assign wr_en_w     = access_w && pwrite && aligned_w && is_mapped(idx_w);

   // ready one cycle after setup keeps every access at fixed length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (clk_en) begin
         pready_ff  <= setup_w;
         pslverr_ff <= nxt_pslverr;
      end
   end

   lsd_cfg_regs u_regs (
      .pclk                (pclk),
      .presetn             (presetn),
      .ce                  (clk_en),
      .wr_en               (wr_en_w),
      .wr_idx              (idx_w),
      .wr_data             (pwdata[7:0]),
      .rd_en               (setup_w),
      .rd_idx              (idx_w),
      .rd_data             (cfg_rd),
      .attr_flat           (cfg_attr),
      .hole_on             (cfg_hole_on),
      .config_freeze       (cfg_frozen),
      .row_fill_third_dimm (cfg_row2)
   );

   // one classifier per initiator so both can be steered in the same cycle
   lsd_seg_lookup u_host_lu (
      .addr      (host_addr),
      .attr_flat (cfg_attr),
      .hole_on   (cfg_hole_on),
      .in_legacy (h_legacy),
      .attr_re   (h_re),
      .attr_we   (h_we),
      .in_hole   (h_hole),
      .dram_rd   (h_dram_rd),
      .dram_wr   (h_dram_wr)
   );

   lsd_seg_lookup u_peer_lu (
      .addr      (peer_addr),
      .attr_flat (cfg_attr),
      .hole_on   (cfg_hole_on),
      .in_legacy (p_legacy),
      .attr_re   (p_re),
      .attr_we   (p_we),
      .in_hole   (p_hole),
      .dram_rd   (p_dram_rd),
      .dram_wr   (p_dram_wr)
   );

   // host steering: the decision stands until the next request
   assign nxt_host_dram  = host_req ? (host_wr ? h_dram_wr : h_dram_rd)
                                    : host_dram_ff;
   assign nxt_host_hub   = host_req ? !(host_wr ? h_dram_wr : h_dram_rd)
                                    : host_hub_ff;
   // peer claim uses the same attributes; hole and vga never claimed
   assign nxt_peer_claim = peer_req ? (peer_wr ? p_dram_wr : p_dram_rd)
                                    : peer_claim_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_done_ff <= 1'b0;
         host_dram_ff <= 1'b0;
         host_hub_ff  <= 1'b0;
      end else if (clk_en) begin
         host_done_ff <= host_req;
         host_dram_ff <= nxt_host_dram;
         host_hub_ff  <= nxt_host_hub;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peer_done_ff  <= 1'b0;
         peer_claim_ff <= 1'b0;
      end else if (clk_en) begin
         peer_done_ff  <= peer_req;
         peer_claim_ff <= nxt_peer_claim;
      end
   end

   assign prdata       = {24'h000000, cfg_rd};
   assign pready       = pready_ff;
   assign pslverr      = pslverr_ff;
   assign host_done    = host_done_ff;
   assign host_to_dram = host_dram_ff;
   assign host_to_hub  = host_hub_ff;
   assign peer_done    = peer_done_ff;
   assign peer_claim   = peer_claim_ff;

   // checks: all sampled on pclk, off while reset is low
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_apb_ready: assert property (
      clk_en && setup_w |=> pready ##1 (!pready || !clk_en))
      else $error("pready not a single cycle after setup");

   a_hole_host: assert property (
      clk_en && host_req && cfg_hole_on && host_addr >= HOLE_BASE
      && host_addr < HOLE_END |=> host_to_hub && !host_to_dram && host_done)
      else $error("host hole cycle not sent to hub");

   a_hole_peer: assert property (
      clk_en && peer_req && cfg_hole_on && peer_addr >= HOLE_BASE
      && peer_addr < HOLE_END |=> !peer_claim && peer_done)
      else $error("peer hole cycle claimed");

   a_hole_no_remap: assert property (
      clk_en && host_req && cfg_hole_on && host_addr >= HOLE_END
      && host_addr < DRAM_LIMIT |=> host_to_dram)
      else $error("dram above hole moved");

   a_population_lock: assert property (
      cfg_frozen |=> $stable(cfg_row2) && cfg_frozen)
      else $error("locked population register changed");

   a_population_width: assert property (
      cfg_row2[7:4] == 4'h0)
      else $error("population code above bit 3");

   a_dram_limit: assert property (
      clk_en && host_req && host_addr >= DRAM_LIMIT |=> host_to_hub)
      else $error("host cycle above 512 MB sent to dram");

   a_disabled_seg: assert property (
      clk_en && peer_req && p_legacy && !p_re && !p_we |=> !peer_claim)
      else $error("peer claimed in disabled segment");

   a_read_only: assert property (
      clk_en && host_req && h_legacy && h_re && !h_we
      |=> host_to_dram == !$past(host_wr))
      else $error("read only segment misrouted");

   a_write_only: assert property (
      clk_en && peer_req && p_legacy && !p_re && p_we
      |=> peer_claim == $past(peer_wr))
      else $error("write only segment peer claim wrong");

   a_read_write: assert property (
      clk_en && host_req && h_legacy && h_re && h_we |=> host_to_dram && !host_to_hub)
      else $error("read write segment not sent to dram");

   a_bios_segment: assert property (
      clk_en && host_req && !host_wr && host_addr >= SYS_BIOS_BASE
      && host_addr < ONE_MB |=> host_to_dram == $past(cfg_attr[4]))
      else $error("system firmware segment read misrouted");

   a_reserved_zero: assert property (
      (cfg_attr[3:0] == 4'h0) && (cfg_attr[15:14] == 2'h0)
      && (cfg_attr[55:54] == 2'h0) && (cfg_attr[51:50] == 2'h0))
      else $error("reserved attribute bits set");

   a_reset_clear: assert property (
      $rose(presetn) |-> cfg_attr == 56'h0 && !cfg_hole_on && cfg_row2 == 8'h00)
      else $error("registers not cleared by reset");

   a_hole_off: assert property (
      clk_en && host_req && !cfg_hole_on && host_addr >= HOLE_BASE
      && host_addr < HOLE_END |=> host_to_dram)
      else $error("disabled hole hid dram");

   a_below_hole: assert property (
      clk_en && host_req && cfg_hole_on && host_addr >= ONE_MB
      && host_addr < HOLE_BASE |=> host_to_dram)
      else $error("dram below hole moved");

   a_low_memory: assert property (
      clk_en && host_req && host_addr < VGA_BASE |=> host_to_dram)
      else $error("low memory not sent to dram");

   a_peer_limit: assert property (
      clk_en && peer_req && peer_addr >= DRAM_LIMIT |=> !peer_claim)
      else $error("peer cycle above 512 MB claimed");

   a_peer_seg_rd: assert property (
      clk_en && peer_req && p_legacy && !peer_wr |=> peer_claim == $past(p_re))
      else $error("peer read ignores read enable");

   a_peer_seg_wr: assert property (
      clk_en && peer_req && p_legacy && peer_wr |=> peer_claim == $past(p_we))
      else $error("peer write ignores write enable");

   a_host_seg_rd: assert property (
      clk_en && host_req && h_legacy && !host_wr |=> host_to_dram == $past(h_re))
      else $error("host read ignores read enable");

   a_host_seg_wr: assert property (
      clk_en && host_req && h_legacy && host_wr |=> host_to_dram == $past(h_we))
      else $error("host write ignores write enable");

   a_we_nibble: assert property (
      clk_en && host_req && host_wr && host_addr[31:14] == 18'h00031
      |=> host_to_dram == $past(cfg_attr[13]))
      else $error("write enable not taken from bit 5");

   a_host_disabled: assert property (
      clk_en && host_req && h_legacy && !h_re && !h_we |=> host_to_hub && !host_to_dram)
      else $error("disabled segment reached dram");

   a_peer_read_only: assert property (
      clk_en && peer_req && p_legacy && p_re && !p_we
      |=> peer_claim == !$past(peer_wr))
      else $error("read only peer claim wrong");

   a_host_write_only: assert property (
      clk_en && host_req && h_legacy && !h_re && h_we
      |=> host_to_dram == $past(host_wr))
      else $error("write only segment misrouted");

   a_peer_read_write: assert property (
      clk_en && peer_req && p_legacy && p_re && p_we |=> peer_claim)
      else $error("read write peer cycle not claimed");

   a_exp_segment: assert property (
      clk_en && host_req && !host_wr && host_addr[31:14] == 18'h00037
      |=> host_to_dram == $past(cfg_attr[36]))
      else $error("last expansion segment wrong nibble");

   a_ext_segment: assert property (
      clk_en && host_req && !host_wr && host_addr[31:14] == 18'h00038
      |=> host_to_dram == $past(cfg_attr[40]))
      else $error("first extended segment wrong nibble");

   a_reset_outputs: assert property (
      $rose(presetn) |-> !pready && !pslverr && !host_done && !host_to_dram
      && !host_to_hub && !peer_done && !peer_claim && prdata == 32'h0)
      else $error("outputs not cleared by reset");

   a_reserved_all: assert property (
      (cfg_attr & 56'hCC_CCCC_CCCC_CCCF) == 56'h0)
      else $error("reserved attribute bit set");

   c_shadow_copy: cover property (
      clk_en && host_req && h_legacy && !h_re && h_we ##1 host_done);

   c_hole_hit: cover property (
      clk_en && peer_req && p_hole ##1 peer_done);

   c_locked_write: cover property (
      cfg_frozen && wr_en_w && idx_w == IDX_ROW_FILL2);

   c_apb_error: cover property (
      access_w && pslverr);
endmodule

/* File: core/lsd_pkg.sv */
// shared constants and types of the legacy segment decoder
package lsd_pkg;
   typedef logic [7:0]  lsd_byte_t;
   typedef logic [31:0] lsd_word_t;
   typedef logic [31:0] lsd_addr_t;
   typedef logic [9:0]  lsd_apb_addr_t;

   localparam int        NUM_ATTR      = 7;
   localparam lsd_byte_t IDX_ROW_FILL1 = 8'h52;
   localparam lsd_byte_t IDX_ROW_FILL2 = 8'h54;
   localparam lsd_byte_t IDX_HOLE      = 8'h58;
   localparam lsd_byte_t IDX_ATTR0     = 8'h59;
   localparam lsd_byte_t IDX_SYSMGMT_RAM_CTL     = 8'h70;

   localparam lsd_byte_t RST_REG       = 8'h00;
   localparam lsd_byte_t MASK_ROW_FILL = 8'h0F;
   localparam lsd_byte_t MASK_HOLE     = 8'h80;
   localparam lsd_byte_t MASK_ATTR     = 8'h33;
   localparam lsd_byte_t MASK_ATTR0    = 8'h30;
   localparam lsd_byte_t MASK_SYSMGMT_RAM_CTL    = 8'h02;
   localparam int        HOLE_ON_BIT   = 7;
   localparam int        ATTR_RE_BIT   = 0;
   localparam int        ATTR_WE_BIT   = 1;

   localparam lsd_addr_t VGA_BASE      = 32'h000A_0000;
   localparam lsd_addr_t EXP_BASE      = 32'h000C_0000;
   localparam lsd_addr_t SYS_BIOS_BASE = 32'h000F_0000;
   localparam lsd_addr_t ONE_MB        = 32'h0010_0000;
   localparam lsd_addr_t HOLE_BASE     = 32'h00F0_0000;
   localparam lsd_addr_t HOLE_END      = 32'h0100_0000;
   localparam lsd_addr_t DRAM_LIMIT    = 32'h2000_0000;
   localparam logic [5:0] SEG_BASE     = 6'h30;
endpackage

/* File: core/lsd_cfg_regs.sv */
// configuration register store with registered read port
`timescale 1ns/1ps
module lsd_cfg_regs (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              wr_en,
   input  wire lsd_pkg::lsd_byte_t wr_idx,
   input  wire lsd_pkg::lsd_byte_t wr_data,
   input  wire logic              rd_en,
   input  wire lsd_pkg::lsd_byte_t rd_idx,
   output wire lsd_pkg::lsd_byte_t rd_data,
   output wire logic [55:0]       attr_flat,
   output wire logic              hole_on,
   output wire logic              config_freeze,
   output wire lsd_pkg::lsd_byte_t row_fill_third_dimm
);
   import lsd_pkg::*;

   lsd_byte_t attr_ff [NUM_ATTR];
   lsd_byte_t row1_ff, row2_ff, hole_ff, rd_data_ff, nxt_rd_data;
   logic      config_freeze_ff;
   logic      attr_rd;
   logic [2:0] attr_sel;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_ATTR; gi++) begin : g_attr
         wire lsd_byte_t mask_w = (gi == 0) ? MASK_ATTR0 : MASK_ATTR;
         wire logic      hit_w  = wr_en && (wr_idx == IDX_ATTR0 + 8'(gi));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               attr_ff[gi] <= RST_REG;
            else if (ce && hit_w)
               attr_ff[gi] <= wr_data & mask_w;
         end
         assign attr_flat[gi*8 +: 8] = attr_ff[gi];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         row1_ff          <= RST_REG;
         row2_ff          <= RST_REG;
         hole_ff          <= RST_REG;
         config_freeze_ff <= 1'b0;
      end else if (ce && wr_en) begin
         if (wr_idx == IDX_ROW_FILL1)
            row1_ff <= wr_data;
         if (wr_idx == IDX_ROW_FILL2 && !config_freeze_ff)
            row2_ff <= wr_data & MASK_ROW_FILL;
         if (wr_idx == IDX_HOLE)
            hole_ff <= wr_data & MASK_HOLE;
         // lock is set-only: only reset reopens the population register
         if (wr_idx == IDX_SYSMGMT_RAM_CTL)
            config_freeze_ff <= config_freeze_ff | (|(wr_data & MASK_SYSMGMT_RAM_CTL));
      end
   end

   assign attr_sel    = 3'(rd_idx - IDX_ATTR0);
   assign attr_rd     = (rd_idx >= IDX_ATTR0) && (rd_idx < IDX_ATTR0 + 8'(NUM_ATTR));
   assign nxt_rd_data = attr_rd ? attr_ff[attr_sel] :
                        (rd_idx == IDX_ROW_FILL1) ? row1_ff :
                        (rd_idx == IDX_ROW_FILL2) ? row2_ff :
                        (rd_idx == IDX_HOLE) ? hole_ff :
                        (rd_idx == IDX_SYSMGMT_RAM_CTL) ? (MASK_SYSMGMT_RAM_CTL & {8{config_freeze_ff}}) :
                        RST_REG;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rd_data_ff <= RST_REG;
      else if (ce && rd_en)
         rd_data_ff <= nxt_rd_data;
   end

   assign rd_data             = rd_data_ff;
   assign hole_on             = hole_ff[HOLE_ON_BIT];
   assign config_freeze       = config_freeze_ff;
   assign row_fill_third_dimm = row2_ff;
endmodule

/* File: core/lsd_seg_lookup.sv */
// address classifier: legacy segment attributes, hole, window limits
`timescale 1ns/1ps
module lsd_seg_lookup (
   input  wire lsd_pkg::lsd_addr_t addr,
   input  wire logic [55:0]        attr_flat,
   input  wire logic               hole_on,
   output wire logic               in_legacy,
   output wire logic               attr_re,
   output wire logic               attr_we,
   output wire logic               in_hole,
   output wire logic               dram_rd,
   output wire logic               dram_wr
);
   import lsd_pkg::*;

   wire logic       in_bios = (addr >= SYS_BIOS_BASE) && (addr < ONE_MB);
   wire logic       in_vga  = (addr >= VGA_BASE) && (addr < EXP_BASE);
   wire logic       in_ram  = addr < DRAM_LIMIT;
   wire logic [3:0] seg_k   = 4'(addr[19:14] - SEG_BASE);
   wire logic [2:0] reg_i   = in_bios ? 3'h0 : 3'(seg_k[3:1] + 3'h1);
   wire logic       hi_nib  = in_bios | seg_k[0];
   wire lsd_byte_t  byte_w  = attr_flat[{reg_i, 3'h0} +: 8];
   wire logic [3:0] nib_w   = hi_nib ? byte_w[7:4] : byte_w[3:0];

   assign in_legacy = (addr >= EXP_BASE) && (addr < ONE_MB);
   assign attr_re   = in_legacy & nib_w[ATTR_RE_BIT];
   assign attr_we   = in_legacy & nib_w[ATTR_WE_BIT];
   // the hole only hides dram: nothing below it is moved elsewhere
   assign in_hole   = hole_on && (addr >= HOLE_BASE) && (addr < HOLE_END);
   assign dram_rd   = in_ram & ~in_hole & ~in_vga & (~in_legacy | attr_re);
   assign dram_wr   = in_ram & ~in_hole & ~in_vga & (~in_legacy | attr_we);
endmodule

/* File: testbench/lsd_initiator_model.sv */
// initiator model: host processor bus and peer masters issuing single cycles
`timescale 1ns/1ps
module lsd_initiator_model (
   input  wire logic         pclk,
   output lsd_pkg::lsd_addr_t host_addr,
   output logic              host_req,
   output logic              host_wr,
   output lsd_pkg::lsd_addr_t peer_addr,
   output logic              peer_req,
   output logic              peer_wr
);
   import lsd_pkg::*;
   initial begin
      host_req = 1'b0;
      host_wr = 1'b0;
      host_addr = 32'h0000_0000;
      peer_req = 1'b0;
      peer_wr = 1'b0;
      peer_addr = 32'h0000_0000;
   end
   // one request per call, held for exactly the taking edge
   task automatic issue(input logic peer, input logic wr, input lsd_addr_t a);
      @(posedge pclk);
      if (peer) begin
         peer_req <= 1'b1;
         peer_wr <= wr;
         peer_addr <= a;
      end else begin
         host_req <= 1'b1;
         host_wr <= wr;
         host_addr <= a;
      end
      @(posedge pclk);
      host_req <= 1'b0;
      peer_req <= 1'b0;
      // released lines flip so a stale address never passes for a held one
      if (peer) begin
         peer_addr <= ~a;
         peer_wr <= ~wr;
      end else begin
         host_addr <= ~a;
         host_wr <= ~wr;
      end
   endtask
endmodule

/* File: testbench/lsd_top_tb.sv */
// self-checking bench of the legacy segment decoder
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module lsd_top_tb;
   import lsd_pkg::*;
   logic          pclk = 1'b0;
   logic          presetn = 1'b0;
   logic          clk_en = 1'b1;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   lsd_apb_addr_t paddr = 10'h000;
   lsd_word_t     pwdata = 32'h0000_0000;
   lsd_word_t     prdata;
   logic          pready, pslverr;
   logic          host_req, host_wr, host_done, host_to_dram, host_to_hub;
   logic          peer_req, peer_wr, peer_done, peer_claim;
   lsd_addr_t     host_addr, peer_addr;
   int            fail_count = 0;
   int            samples_checked = 0;

   always #4 pclk = ~pclk;

   lsd_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .host_req(host_req), .host_wr(host_wr),
      .host_addr(host_addr), .host_done(host_done), .host_to_dram(host_to_dram),
      .host_to_hub(host_to_hub), .peer_req(peer_req), .peer_wr(peer_wr),
      .peer_addr(peer_addr), .peer_done(peer_done), .peer_claim(peer_claim));
   lsd_initiator_model ini (.pclk(pclk), .host_addr(host_addr), .host_req(host_req),
      .host_wr(host_wr), .peer_addr(peer_addr), .peer_req(peer_req), .peer_wr(peer_wr));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic lsd_apb_addr_t ba(input lsd_byte_t idx);
      return {idx, 2'b00};
   endfunction

   task automatic apb(input logic w, input lsd_apb_addr_t a, input lsd_byte_t d,
                      output lsd_word_t rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      if (pready !== 1'b1) begin
         fail_count++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~pwdata;
   endtask

   task automatic wr(input lsd_apb_addr_t a, input lsd_byte_t d);
      lsd_word_t rd;
      logic err;
      apb(1'b1, a, d, rd, err);
      `CHK("pslverr on write", 1'b0, err)
   endtask

   task automatic rdchk(input lsd_apb_addr_t a, input lsd_byte_t ex, input logic ex_err);
      lsd_word_t rd;
      logic err;
      apb(1'b0, a, 8'h00, rd, err);
      `CHK("prdata", {24'h00_0000, ex}, rd)
      `CHK("pslverr on read", ex_err, err)
   endtask

   // one host or peer cycle; ex is the dram decision or the peer claim
   task automatic cyc(input logic peer, input logic w, input lsd_addr_t a, input logic ex);
      int n;
      ini.issue(peer, w, a);
      #1;
      for (n = 0; n < 4 && (peer ? peer_done : host_done) !== 1'b1; n++) @(posedge pclk) #1;
      if (n == 4) begin
         fail_count++;
         stop_test();
      end
      if (peer) begin
         `CHK("peer_claim", ex, peer_claim)
      end else begin
         `CHK("host_to_dram", ex, host_to_dram)
         `CHK("host_to_hub", ~ex, host_to_hub)
      end
   endtask

   task automatic t_reset_and_reserved;
      int i;
      rdchk(ba(IDX_ROW_FILL2), RST_REG, 1'b0);
      rdchk(ba(IDX_HOLE), RST_REG, 1'b0);
      for (i = 0; i < NUM_ATTR; i++) rdchk(ba(IDX_ATTR0 + 8'(i)), RST_REG, 1'b0);
      wr(ba(IDX_HOLE), 8'hFF);
      rdchk(ba(IDX_HOLE), 8'h80, 1'b0);
      wr(ba(IDX_ATTR0), 8'hFF);
      rdchk(ba(IDX_ATTR0), 8'h30, 1'b0);
      for (i = 1; i < NUM_ATTR; i++) begin
         wr(ba(IDX_ATTR0 + 8'(i)), 8'hFF);
         rdchk(ba(IDX_ATTR0 + 8'(i)), 8'h33, 1'b0);
         wr(ba(IDX_ATTR0 + 8'(i)), 8'h00);
      end
      wr(ba(IDX_ATTR0), 8'h00);
      wr(ba(IDX_HOLE), 8'h00);
      wr(ba(IDX_ROW_FILL2), 8'hFF);
      rdchk(ba(IDX_ROW_FILL2), 8'h0F, 1'b0);
      rdchk(10'h3FC, 8'h00, 1'b1);
      // a misaligned read is flagged but still returns the addressed word
      rdchk(ba(IDX_ROW_FILL2) + 10'h001, MASK_ROW_FILL, 1'b1);
   endtask

   task automatic t_modes;
      int s;
      int m;
      int sh;
      lsd_addr_t a;
      lsd_byte_t ix;
      for (s = 0; s < 13; s++) begin
         a = (s < 12) ? EXP_BASE + s * 32'h4000 : SYS_BIOS_BASE;
         ix = (s < 12) ? IDX_ATTR0 + 8'(1 + s / 2) : IDX_ATTR0;
         sh = (s < 12) ? 4 * (s % 2) : 4;
         for (m = 0; m < 4; m++) begin
            wr(ba(ix), 8'(m << sh));
            cyc(1'b0, 1'b0, a, m[0]);
            cyc(1'b0, 1'b1, a + 32'h3FFF, m[1]);
            cyc(1'b1, 1'b0, a + 32'h2000, m[0]);
            cyc(1'b1, 1'b1, a, m[1]);
            if (s < 11) cyc(1'b0, 1'b0, a + 32'h4000, 1'b0);
         end
         wr(ba(ix), 8'h00);
      end
   endtask

   task automatic t_hole_and_limit;
      cyc(1'b0, 1'b0, HOLE_BASE, 1'b1);
      wr(ba(IDX_HOLE), 8'h80);
      cyc(1'b0, 1'b0, HOLE_BASE, 1'b0);
      cyc(1'b0, 1'b1, HOLE_END - 32'h1, 1'b0);
      cyc(1'b1, 1'b0, HOLE_BASE, 1'b0);
      cyc(1'b1, 1'b1, HOLE_END - 32'h1, 1'b0);
      cyc(1'b1, 1'b0, HOLE_BASE - 32'h1, 1'b1);
      cyc(1'b0, 1'b0, HOLE_END, 1'b1);
      cyc(1'b0, 1'b1, HOLE_BASE - 32'h1, 1'b1);
      wr(ba(IDX_HOLE), 8'h00);
      cyc(1'b0, 1'b1, HOLE_BASE, 1'b1);
      cyc(1'b0, 1'b0, DRAM_LIMIT - 32'h1, 1'b1);
      cyc(1'b0, 1'b1, DRAM_LIMIT, 1'b0);
      cyc(1'b1, 1'b0, DRAM_LIMIT, 1'b0);
      // video range sits outside every attribute and always goes to the hub
      cyc(1'b0, 1'b0, VGA_BASE - 32'h1, 1'b1);
      cyc(1'b0, 1'b0, VGA_BASE, 1'b0);
   endtask

   // firmware copy: write-only while copying, then read-only to protect it
   task automatic t_shadow;
      wr(ba(IDX_ATTR0), 8'h20);
      cyc(1'b0, 1'b0, SYS_BIOS_BASE + 32'h100, 1'b0);
      cyc(1'b0, 1'b1, SYS_BIOS_BASE + 32'h100, 1'b1);
      wr(ba(IDX_ATTR0), 8'h10);
      cyc(1'b0, 1'b1, SYS_BIOS_BASE + 32'h100, 1'b0);
      cyc(1'b0, 1'b0, SYS_BIOS_BASE + 32'h100, 1'b1);
      wr(ba(IDX_ATTR0), 8'h00);
   endtask

   // lock is set-only: only a reset reopens the population register
   task automatic t_lock;
      wr(ba(IDX_ROW_FILL1), 8'hA5);
      rdchk(ba(IDX_ROW_FILL1), 8'hA5, 1'b0);
      wr(ba(IDX_ROW_FILL2), 8'h05);
      rdchk(ba(IDX_ROW_FILL2), 8'h05, 1'b0);
      wr(ba(IDX_SYSMGMT_RAM_CTL), 8'h02);
      rdchk(ba(IDX_SYSMGMT_RAM_CTL), 8'h02, 1'b0);
      wr(ba(IDX_ROW_FILL2), 8'h0A);
      rdchk(ba(IDX_ROW_FILL2), 8'h05, 1'b0);
      wr(ba(IDX_SYSMGMT_RAM_CTL), 8'h00);
      rdchk(ba(IDX_SYSMGMT_RAM_CTL), 8'h02, 1'b0);
   endtask

   // reset in mid-run clears the lock and the population register
   task automatic t_reset_mid;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(ba(IDX_ROW_FILL2), RST_REG, 1'b0);
      rdchk(ba(IDX_SYSMGMT_RAM_CTL), RST_REG, 1'b0);
      wr(ba(IDX_ROW_FILL2), 8'h03);
      rdchk(ba(IDX_ROW_FILL2), 8'h03, 1'b0);
   endtask

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_and_reserved();
      t_modes();
      t_hole_and_limit();
      t_shadow();
      t_lock();
      t_reset_mid();
      stop_test();
   end
endmodule
